// >>> icc_pkg.sv
// constants and types for the four-channel incremental counter block
// assumes a 100 MHz system clock; the count clock is an enable derived from it
package icc_pkg;
  localparam int NUM_CH          = 4;
  localparam int SAMPLE_W        = 16;  // signed input level in millivolts
  localparam int PERIOD_W        = 24;
  localparam int POS_W           = 32;
  // clock rates; the count enable is a fractional divide of the system clock
  localparam int CLK_FREQ_MHZ    = 100;
  localparam int CNT_FREQ_MHZ    = 32;
  localparam int ACC_W           = 8;
  localparam logic [ACC_W-1:0] ACC_STEP  = ACC_W'(CNT_FREQ_MHZ);
  localparam logic [ACC_W-1:0] ACC_WRAP  = ACC_W'(CLK_FREQ_MHZ);
  // detector threshold and hysteresis in millivolts
  localparam int DET_THRESHOLD_MV   = 1500;
  localparam int DETECTOR_HYSTERESIS_MV = 500;
  localparam logic signed [SAMPLE_W-1:0] DET_RISE_MV =
    SAMPLE_W'(DET_THRESHOLD_MV + DETECTOR_HYSTERESIS_MV / 2);
  localparam logic signed [SAMPLE_W-1:0] DET_FALL_MV =
    SAMPLE_W'(DET_THRESHOLD_MV - DETECTOR_HYSTERESIS_MV / 2);
  // reset values, count steps and the period saturation limit
  localparam logic [PERIOD_W-1:0] PERIOD_RST = 24'h000000;
  localparam logic [PERIOD_W-1:0] PERIOD_MAX = 24'hffffff;
  localparam logic [POS_W-1:0]    POS_RST    = 32'h00000000;
  localparam logic [POS_W-1:0]    POS_ONE    = 32'h00000001;
  localparam logic [POS_W-1:0]    POS_MINUS1 = 32'hffffffff;
  localparam logic [PERIOD_W-1:0] PERIOD_ONE = 24'h000001;
  // gate of the counters after a measurement start
  typedef enum logic [1:0] {GATE_IDLE, GATE_WAIT_INDEX, GATE_RUN} icc_gate_t;
endpackage

// >>> icc_counter.sv
// four-channel incremental counter: detectors, synchronisers, count gate,
// period timing on the primary track and quadrature direction
// assumes track and index levels arrive as signed millivolt samples on clock
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - counters wait for index rise unless index-free
// - index start armed only by a run rise; run drop cancels it
// - quadrature phase gives direction on dual tracks
// - direction only in dual-track encoder type
// - timing uses primary track edges only
// - single-track types: no sign, primary only
// - per-channel interval counter at 32 MHz
// - sample tick only latches results for readout
// - detector hysteresis about threshold, half each side
// - threshold 1.5 V, hysteresis 0.5 V fixed
// - index uses first channel detector settings
// - open index settles high, no edge
// - one index acts on all four channels
////////////////////////////////////////////////////////////////////////////////
module icc_counter
  import icc_pkg::*;
(
  // clock and reset
  input  wire logic                                   clock,
  input  wire logic                                   arst_n,
  // analog track samples, primary and secondary per channel
  input  wire logic [NUM_CH-1:0][SAMPLE_W-1:0]        trk_pri_mv,
  input  wire logic [NUM_CH-1:0][SAMPLE_W-1:0]        trk_sec_mv,
  // index input and its presence
  input  wire logic [SAMPLE_W-1:0]                    index_mv,
  input  wire logic                                   index_present,
  // configuration
  input  wire logic                                   index_free_mode,
  input  wire logic [NUM_CH-1:0]                      dual_track,
  // measurement control
  input  wire logic                                   meas_run,
  input  wire logic                                   sample_tick,
  // results, refreshed on each sample tick; counting_q follows the gate every clock
  output logic      [NUM_CH-1:0][PERIOD_W-1:0]        period_q,
  output logic      [NUM_CH-1:0][POS_W-1:0]           position_q,
  output logic      [NUM_CH-1:0]                      dir_down_q,
  output logic      [NUM_CH-1:0]                      dir_valid_q,
  output logic                                        counting_q
);

  ////////////////////////////////////////////////////////////////////////////
  // count clock enable, 32 MHz average from 100 MHz by phase accumulation
  logic [ACC_W-1:0] acc_q;
  logic             cnt_en_q;

  // fractional divide keeps one clock; jitter of one system cycle is traded for it
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      acc_q    <= '0;
      cnt_en_q <= 1'b0;
    end else if (acc_q + ACC_STEP >= ACC_WRAP) begin
      acc_q    <= ACC_W'(acc_q + ACC_STEP - ACC_WRAP);
      cnt_en_q <= 1'b1;
    end else begin
      acc_q    <= ACC_W'(acc_q + ACC_STEP);
      cnt_en_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // detectors with hysteresis; index shares channel 0 thresholds
  localparam int NDET = 2 * NUM_CH + 1;
  // index stages reset to the idle high level, else reset itself looks like an index rise
  localparam logic [NDET-1:0] SYNC_RST = {1'b1, {(NDET-1){1'b0}}};
  logic [NDET-1:0][SAMPLE_W-1:0] det_in;
  logic [NDET-1:0]               det_q;
  logic [NDET-1:0]               s1_q;
  logic [NDET-1:0]               s2_q;
  logic [NDET-1:0]               s3_q;
  logic [NDET-1:0]               sync_q;

  // inputs gathered: primaries, secondaries, then the index
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      det_in[i]          = trk_pri_mv[i];
      det_in[NUM_CH + i] = trk_sec_mv[i];
    end
    det_in[NDET-1] = index_mv;
  end

  genvar d;
  generate
    for (d = 0; d < NDET; d++) begin : g_det
      // schmitt action: rise above upper, fall below lower
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          det_q[d] <= (d == NDET - 1); // index idles high
        end else if (d == NDET - 1 && !index_present) begin
          det_q[d] <= 1'b1;
        end else if ($signed(det_in[d]) > DET_RISE_MV) begin
          det_q[d] <= 1'b1;
        end else if ($signed(det_in[d]) < DET_FALL_MV) begin
          det_q[d] <= 1'b0;
        end
      end
    end
  endgenerate

  // synchroniser; a change counts once the second and third stages agree
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s1_q   <= SYNC_RST;
      s2_q   <= SYNC_RST;
      s3_q   <= SYNC_RST;
      sync_q <= SYNC_RST;
    end else begin
      s1_q <= det_q;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < NDET; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          sync_q[i] <= s3_q[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // samples at the count clock rate for edge finding
  logic [NDET-1:0] cs_q;
  logic [NDET-1:0] cs_prev_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cs_q      <= SYNC_RST;
      cs_prev_q <= SYNC_RST;
    end else if (cnt_en_q) begin
      cs_q      <= sync_q;
      cs_prev_q <= cs_q;
    end
  end

  logic index_rise;
  assign index_rise = cnt_en_q && cs_q[NDET-1] && !cs_prev_q[NDET-1];

  ////////////////////////////////////////////////////////////////////////////
  // count gate common to all channels
  icc_gate_t gate_q;
  logic      run_prev_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      gate_q     <= GATE_IDLE;
      run_prev_q <= 1'b0;
    end else begin
      run_prev_q <= meas_run;
      unique case (gate_q)
        GATE_IDLE: begin
          if (meas_run && !run_prev_q) begin
            gate_q <= index_free_mode ? GATE_RUN : GATE_WAIT_INDEX;
          end
        end
        GATE_WAIT_INDEX: begin
          if (!meas_run) begin
            gate_q <= GATE_IDLE;
          end else if (index_rise) begin
            gate_q <= GATE_RUN;
          end
        end
        GATE_RUN: begin
          if (!meas_run) begin
            gate_q <= GATE_IDLE;
          end
        end
      endcase
    end
  end

  logic counting;
  assign counting = (gate_q == GATE_RUN);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      counting_q <= 1'b0;
    end else begin
      counting_q <= counting;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel timing, position and direction
  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++) begin : g_ch
      logic [PERIOD_W-1:0] tick_cnt_q;
      logic [PERIOD_W-1:0] last_period_q;
      logic [POS_W-1:0]    pos_q;
      logic                down_q;
      logic                seen_edge_q;
      logic                pri_rise;

      // only the primary track starts and stops an interval
      assign pri_rise = cnt_en_q && cs_q[c] && !cs_prev_q[c];

      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          tick_cnt_q    <= PERIOD_RST;
          last_period_q <= PERIOD_RST;
          seen_edge_q   <= 1'b0;
        end else if (!counting) begin
          tick_cnt_q    <= PERIOD_RST; // held in reset until gate opens
          last_period_q <= PERIOD_RST;
          seen_edge_q   <= 1'b0;
        end else if (pri_rise) begin
          tick_cnt_q  <= PERIOD_ONE;
          seen_edge_q <= 1'b1;
          if (seen_edge_q) begin
            last_period_q <= tick_cnt_q;
          end
        end else if (cnt_en_q && tick_cnt_q != PERIOD_MAX) begin
          tick_cnt_q <= PERIOD_W'(tick_cnt_q + PERIOD_ONE); // saturates on stall
        end
      end

      // b low at a rising a means a leads b by a quarter period
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          pos_q  <= POS_RST;
          down_q <= 1'b0;
        end else if (!counting) begin
          pos_q  <= POS_RST;
          down_q <= 1'b0;
        end else if (pri_rise) begin
          if (dual_track[c]) begin
            down_q <= cs_q[NUM_CH + c];
            pos_q  <= POS_W'(pos_q + (cs_q[NUM_CH + c] ? POS_MINUS1 : POS_ONE));
          end else begin
            down_q <= 1'b0;
            pos_q  <= POS_W'(pos_q + POS_ONE);
          end
        end
      end

      // readout at the user rate; inputs are not sampled by it
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          period_q[c]    <= PERIOD_RST;
          position_q[c]  <= POS_RST;
          dir_down_q[c]  <= 1'b0;
          dir_valid_q[c] <= 1'b0;
        end else if (sample_tick) begin
          period_q[c]    <= last_period_q;
          position_q[c]  <= pos_q;
          dir_down_q[c]  <= down_q && dual_track[c] && counting;
          dir_valid_q[c] <= dual_track[c] && counting;
        end
      end
    end
  endgenerate

endmodule

// >>> icc_counter_chk.sv
// port checker for the four-channel incremental counter
// assumes one clock domain and the async active-low reset of the block
`timescale 1ns/100ps
module icc_counter_chk
  import icc_pkg::*;
(
  // clock and reset
  input wire logic                            clock,
  input wire logic                            arst_n,
  // configuration and control
  input wire logic                            index_present,
  input wire logic                            index_free_mode,
  input wire logic [NUM_CH-1:0]               dual_track,
  input wire logic                            meas_run,
  input wire logic                            sample_tick,
  // results
  input wire logic [NUM_CH-1:0][PERIOD_W-1:0] period_q,
  input wire logic [NUM_CH-1:0][POS_W-1:0]    position_q,
  input wire logic [NUM_CH-1:0]               dir_down_q,
  input wire logic [NUM_CH-1:0]               dir_valid_q,
  input wire logic                            counting_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  //////////////////////////////////////////////////////////////////////////////
  // readout only moves on the cycle after a tick
  pos_hold_a: assert property (!$past(sample_tick) |-> $stable(position_q))
    else $error("position changed without a tick");
  dir_hold_a: assert property (!$past(sample_tick) |-> $stable(dir_down_q) && $stable(period_q))
    else $error("direction or period changed without a tick");
  // sign only for dual-track channels
  valid_dual_a: assert property ($past(sample_tick) |-> (dir_valid_q & ~$past(dual_track)) == 4'h0)
    else $error("direction valid on a single-track channel");
  down_valid_a: assert property (|dir_down_q |-> (dir_down_q & ~dir_valid_q) == 4'h0)
    else $error("direction down without valid");
  // gate opens at once without index, closes when run drops
  free_start_a: assert property ($rose(meas_run) && index_free_mode |-> ##[1:3] (counting_q || !meas_run))
    else $error("index-free start did not open the gate");
  stop_idle_a: assert property (!meas_run |-> ##2 !counting_q)
    else $error("gate still open after run dropped");
  // an open index can never start the counters
  open_index_a: assert property (!index_free_mode && !index_present && $past(index_present, 8) == 1'b0
    && !counting_q |=> !counting_q) else $error("gate opened with open index");
  idle_zero_a: assert property ((!meas_run)[*4] ##1 sample_tick |=> position_q == '0 && period_q == '0
    && dir_valid_q == '0) else $error("idle results not zero");
endmodule
bind icc_counter icc_counter_chk chk_u (.clock(clock), .arst_n(arst_n), .index_present(index_present),
  .index_free_mode(index_free_mode), .dual_track(dual_track), .meas_run(meas_run), .sample_tick(sample_tick),
  .period_q(period_q), .position_q(position_q), .dir_down_q(dir_down_q), .dir_valid_q(dir_valid_q),
  .counting_q(counting_q));

// >>> icc_enc_model.sv
// quadrature encoder model: two tracks a quarter period apart plus index
// assumes the bench requests one phase step per pulse on step_fwd or step_rev
`timescale 1ns/100ps
module icc_enc_model
  import icc_pkg::*;
(
  // clock and reset
  input  wire logic                            clock,
  input  wire logic                            arst_n,
  // motion and levels
  input  wire logic                            step_fwd,
  input  wire logic                            step_rev,
  input  wire logic                            index_hi,
  input  wire logic [SAMPLE_W-1:0]             hi_mv,
  // analog levels, low is 0 mV
  output logic      [NUM_CH-1:0][SAMPLE_W-1:0] trk_pri_mv,
  output logic      [NUM_CH-1:0][SAMPLE_W-1:0] trk_sec_mv,
  output logic      [SAMPLE_W-1:0]             index_mv
);
  logic [1:0] phase_q;
  // phase walks 0..3 forward, so the primary leads
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) phase_q <= 2'h0;
    else if (step_fwd) phase_q <= phase_q + 2'h1;
    else if (step_rev) phase_q <= phase_q - 2'h1;
  end
  // same motion on every channel; index shares the track level
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      trk_pri_mv[c] = (phase_q == 2'h1 || phase_q == 2'h2) ? hi_mv : 16'h0000;
      trk_sec_mv[c] = phase_q[1] ? hi_mv : 16'h0000;
    end
    index_mv = index_hi ? hi_mv : 16'h0000;
  end
endmodule

// >>> test_incremental_counter_channels.sv
// bench for the incremental counter: encoder model drives tracks, bench controls
// assumes 100 MHz clock, inputs driven on the falling edge
`timescale 1ns/100ps
module test_incremental_counter_channels
  import icc_pkg::*;
  ;
  logic clock = 0, arst_n = 0, index_present = 0, index_free_mode = 0, meas_run = 0;
  logic sample_tick = 0, step_fwd = 0, step_rev = 0, index_hi = 0, counting_q;
  logic [NUM_CH-1:0] dual_track = 4'h3, dir_down_q, dir_valid_q;
  logic [SAMPLE_W-1:0] hi_mv = 16'h0bb8, index_mv;
  logic [NUM_CH-1:0][SAMPLE_W-1:0] trk_pri_mv, trk_sec_mv;
  logic [NUM_CH-1:0][PERIOD_W-1:0] period_q;
  logic [NUM_CH-1:0][POS_W-1:0] position_q;
  int miscompares = 0, tests_run = 0;
  icc_enc_model enc_u (.clock(clock), .arst_n(arst_n), .step_fwd(step_fwd), .step_rev(step_rev),
    .index_hi(index_hi), .hi_mv(hi_mv), .trk_pri_mv(trk_pri_mv), .trk_sec_mv(trk_sec_mv), .index_mv(index_mv));
  icc_counter dut_u (.clock(clock), .arst_n(arst_n), .trk_pri_mv(trk_pri_mv), .trk_sec_mv(trk_sec_mv),
    .index_mv(index_mv), .index_present(index_present), .index_free_mode(index_free_mode),
    .dual_track(dual_track), .meas_run(meas_run), .sample_tick(sample_tick), .period_q(period_q),
    .position_q(position_q), .dir_down_q(dir_down_q), .dir_valid_q(dir_valid_q), .counting_q(counting_q));
  initial forever #5 clock = ~clock;
  //////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(string what, logic [POS_W-1:0] exp, logic [POS_W-1:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask
  // each phase held 16 cycles, well past the detector latency
  task automatic move(bit fwd, int n);
    repeat (n) begin
      @(negedge clock) {step_fwd, step_rev} = fwd ? 2'b10 : 2'b01;
      @(negedge clock) {step_fwd, step_rev} = 2'b00;
      repeat (14) @(negedge clock);
    end
  endtask
  task automatic tick();
    @(negedge clock) sample_tick = 1;
    @(negedge clock) sample_tick = 0;
    @(negedge clock);
  endtask
  task automatic wait_counting();
    int n;
    n = 0;
    while (counting_q !== 1'b1 && n < 60) begin
      @(negedge clock);
      n++;
    end
    check("counting_q", 1, counting_q);
    if (counting_q !== 1'b1) summarize();
  endtask
  // dual channels expect pd and the given sign, single ones ps and no sign
  task automatic expect_all(int pd, int ps, logic dn);
    for (int c = 0; c < NUM_CH; c++) begin
      check("position_q", dual_track[c] ? pd : ps, position_q[c]);
      check("dir_down_q", dual_track[c] & dn, dir_down_q[c]);
      check("dir_valid_q", dual_track[c], dir_valid_q[c]);
    end
  endtask
  initial begin
    repeat (6) @(negedge clock);
    arst_n = 1;
    check("counting_q", 0, counting_q);
    // open index, run raised: motion must not count
    meas_run = 1;
    move(1, 8);
    tick();
    check("counting_q", 0, counting_q);
    check("position_q", 0, position_q[0]);
    index_present = 1;
    repeat (10) @(negedge clock);
    index_hi = 1;
    wait_counting();
    index_hi = 0;
    // forward four periods; nothing shows before the tick
    move(1, 16);
    check("position_q", 0, position_q[0]);
    tick();
    expect_all(4, 4, 0);
    for (int c = 0; c < NUM_CH; c++)
      check("period_q", 1, period_q[c] == 24'h000014 || period_q[c] == 24'h000015);
    // reverse four periods: dual counts back, single keeps adding
    move(0, 16);
    tick();
    expect_all(0, 8, 1);
    // high level at rise threshold is not enough, one above is
    hi_mv = 16'h06d6;
    move(1, 8);
    tick();
    expect_all(0, 8, 1);
    hi_mv = 16'h06d7;
    move(1, 8);
    tick();
    expect_all(2, 10, 0);
    // stop, then index-free start with no index wired
    meas_run = 0;
    repeat (6) @(negedge clock);
    tick();
    check("counting_q", 0, counting_q);
    check("position_q", 0, position_q[0]);
    index_present = 0;
    index_free_mode = 1;
    meas_run = 1;
    wait_counting();
    summarize();
  end
endmodule
